// File: verilog/sgrc_top.sv
`timescale 1ns/1ps
// Contract
// [RULE1] Gating on, sleep enable clear: stop clock
// [RULE2] Gated peripheral resumes on wake, state kept
// [RULE3] Gating off: sleep enables stored, no effect
// [RULE4] Gating on, sleep enable set: keep clock
// [RULE5] Sleep never alters run clock configuration
// [RULE6] Sleep-clocked peripheral may wake processor
// [RULE7] Gating off: all peripherals clocked in sleep; code clocks only run-enabled ones
// [RULE8] Per-pin presence readable by software
// [RULE9] Software reset resets core and peripherals
// [RULE10] Software reset keeps causes, sets software flag
// [RULE11] Five separate accumulating cause flags
// [RULE12] Flags sticky until cleared or external reset
// [RULE13] Clear selected flags only
// [RULE14] Software clears all flags after reading
// [RULE15] Peripherals start disabled after power-up
// [RULE16] Enable takes five cycles; early access faults
// [RULE17] Per-peripheral reset pulses, peripheral stays enabled
// [RULE18] One bit per cause, same clear mask
// [RULE19] Sleep clock enables registered on system clock
module sgrc_top #(
    parameter int unsigned NP = sgrc_pkg::NUM_PERIPH,
    parameter int unsigned NI = sgrc_pkg::NUM_PINS,
    parameter logic [NP-1:0] PERIPH_PRESENT = '1,
    parameter logic [NI-1:0] PIN_PRESENT    = '1
) (
    // Clock and device reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // Reset cause events, one-cycle pulses during the reset being recorded
    input  wire logic                ev_ext_i,
    input  wire logic                ev_por_i,
    input  wire logic                ev_bor_i,
    input  wire logic                ev_wdog_i,
    // Software controls
    input  wire logic                sw_reset_req_i,
    input  wire logic                gating_en_i,
    input  wire logic [NP-1:0]       run_en_set_i,
    input  wire logic [NP-1:0]       run_en_clr_i,
    input  wire logic [NP-1:0]       sleep_en_set_i,
    input  wire logic [NP-1:0]       sleep_en_clr_i,
    input  wire logic [NP-1:0]       periph_reset_req_i,
    input  wire logic [4:0]          cause_clear_i,
    // Processor sleep handshake
    input  wire logic                sleep_req_i,
    input  wire logic [NP-1:0]       periph_wake_i,
    // Peripheral access check
    input  wire logic [NP-1:0]       periph_access_i,
    // Outputs
    output logic [NP-1:0]            periph_clk_en_o,
    output logic [NP-1:0]            periph_ready_o,
    output logic [NP-1:0]            periph_rst_o,
    output logic                     bus_fault_o,
    output logic                     sys_reset_o,
    output logic                     cpu_sleeping_o,
    output logic                     wake_o,
    output logic [4:0]               cause_o,
    output logic [NP-1:0]            sleep_en_o,
    output logic [NP-1:0]            periph_present_o,
    output logic [NI-1:0]            pin_present_o
);

    sgrc_pkg::sgrc_pstate_t pstate_r;
    logic [NP-1:0]          run_en_r;
    logic [NP-1:0]          sleep_en_r;
    logic [NP-1:0]          clk_en_nxt;
    logic [NP-1:0]          wake_nxt;
    logic [4:0]             cause_r;
    logic [4:0]             cause_set;
    logic                   sw_rst_r;

    // Soft reset pulse: one cycle, clears enables, power state and counters, asserts peripheral resets, sets the software cause flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= sw_reset_req_i & ~sw_rst_r;  // [RULE9]
        end
    end

    assign sys_reset_o = sw_rst_r;  // [RULE9]

    // Cause flags survive the soft reset; external reset wipes older flags
    always_comb begin
        cause_set = '0;
        cause_set[sgrc_pkg::CAUSE_EXT_BIT]  = ev_ext_i;   // [RULE11]
        cause_set[sgrc_pkg::CAUSE_POR_BIT]  = ev_por_i;
        cause_set[sgrc_pkg::CAUSE_BOR_BIT]  = ev_bor_i;
        cause_set[sgrc_pkg::CAUSE_WDOG_BIT] = ev_wdog_i;
        cause_set[sgrc_pkg::CAUSE_SW_BIT]   = sw_rst_r;   // [RULE10]
    end

    // Cause register lives outside the soft reset domain; every device reset clears it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cause_r <= sgrc_pkg::CAUSE_RESET_VAL;
        end else if (ev_ext_i) begin
            cause_r <= cause_set;                                   // [RULE12]
        end else begin
            cause_r <= (cause_r & ~cause_clear_i) | cause_set;      // [RULE13] [RULE18]
        end
    end

    assign cause_o = cause_r;

    // Run and sleep enables, cleared by soft reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_en_r <= '0;                                         // [RULE15]
        end else if (sw_rst_r) begin
            run_en_r <= '0;                                         // [RULE9]
        end else begin
            run_en_r <= (run_en_r & ~run_en_clr_i) | (run_en_set_i & PERIPH_PRESENT);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_en_r <= '0;
        end else if (sw_rst_r) begin
            sleep_en_r <= '0;
        end else begin
            // Kept whatever the gating enable says
            sleep_en_r <= (sleep_en_r & ~sleep_en_clr_i) | sleep_en_set_i;  // [RULE3]
        end
    end

    assign sleep_en_o = sleep_en_r;

    // Processor power state
    always_comb begin
        wake_nxt = periph_wake_i & clk_en_nxt;                       // [RULE6]
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pstate_r <= sgrc_pkg::SGRC_RUN;
        end else if (sw_rst_r) begin
            pstate_r <= sgrc_pkg::SGRC_RUN;
        end else begin
            case (pstate_r)
                sgrc_pkg::SGRC_RUN: begin
                    if (sleep_req_i) begin
                        pstate_r <= sgrc_pkg::SGRC_SLEEP;
                    end
                end
                sgrc_pkg::SGRC_SLEEP: begin
                    if (|wake_nxt) begin
                        pstate_r <= sgrc_pkg::SGRC_RUN;              // [RULE6]
                    end
                end
                default: begin
                    pstate_r <= sgrc_pkg::SGRC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_sleeping_o <= 1'b0;
            wake_o         <= 1'b0;
        end else begin
            cpu_sleeping_o <= (pstate_r == sgrc_pkg::SGRC_SLEEP) & ~sw_rst_r;
            wake_o         <= (pstate_r == sgrc_pkg::SGRC_SLEEP) & (|wake_nxt);
        end
    end

    // Clock enables: sleep only narrows run enables, never touches clock config
    always_comb begin
        if (pstate_r == sgrc_pkg::SGRC_SLEEP && gating_en_i) begin
            clk_en_nxt = run_en_r & sleep_en_r;                      // [RULE1] [RULE4]
        end else begin
            clk_en_nxt = run_en_r;                                   // [RULE2] [RULE5] [RULE7]
        end
    end

    // Registered so the gated clocks never see a combinational glitch
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            periph_clk_en_o <= '0;
        end else if (sw_rst_r) begin
            periph_clk_en_o <= '0;
        end else begin
            periph_clk_en_o <= clk_en_nxt;                           // [RULE19]
        end
    end

    // Per-peripheral enable latency and reset pulse counters
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_periph
            logic [sgrc_pkg::CNT_W-1:0] en_cnt_r;
            logic [sgrc_pkg::CNT_W-1:0] rst_cnt_r;

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    en_cnt_r <= '0;
                end else if (sw_rst_r || !run_en_r[g]) begin
                    en_cnt_r <= '0;
                end else if (en_cnt_r != sgrc_pkg::CNT_W'(sgrc_pkg::ENABLE_LAT_CYC - 1)) begin
                    en_cnt_r <= en_cnt_r + 1'b1;                     // [RULE16]
                end
            end

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    periph_ready_o[g] <= 1'b0;
                end else if (sw_rst_r || !run_en_r[g]) begin
                    periph_ready_o[g] <= 1'b0;
                end else begin
                    periph_ready_o[g] <= (en_cnt_r == sgrc_pkg::CNT_W'(sgrc_pkg::ENABLE_LAT_CYC - 1)); // [RULE16]
                end
            end

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    rst_cnt_r <= '0;
                end else if (sw_rst_r) begin
                    rst_cnt_r <= '0;
                end else if (periph_reset_req_i[g]) begin
                    rst_cnt_r <= sgrc_pkg::CNT_W'(sgrc_pkg::PRST_PULSE_CYC);  // [RULE17]
                end else if (rst_cnt_r != '0) begin
                    rst_cnt_r <= rst_cnt_r - 1'b1;
                end
            end

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    periph_rst_o[g] <= 1'b1;
                end else begin
                    periph_rst_o[g] <= sw_rst_r | periph_reset_req_i[g] | (rst_cnt_r > 1);  // [RULE17] [RULE9]
                end
            end
        end
    endgenerate

    // Access to a peripheral not yet ready is a fault
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_fault_o <= 1'b0;
        end else begin
            bus_fault_o <= |(periph_access_i & ~periph_ready_o);     // [RULE15] [RULE16]
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            periph_present_o <= '0;
            pin_present_o    <= '0;
        end else begin
            periph_present_o <= PERIPH_PRESENT;
            pin_present_o    <= PIN_PRESENT;                         // [RULE8]
        end
    end

    a_gate_off_sleep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE1]
        (pstate_r == sgrc_pkg::SGRC_SLEEP && gating_en_i && !sw_rst_r && run_en_r[0] && !sleep_en_r[0])
        |=> !periph_clk_en_o[0])
        else $error("peripheral clocked in sleep without sleep enable");

    a_gate_keep_on: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE4]
        (gating_en_i && !sw_rst_r && run_en_r[1] && sleep_en_r[1]) |=> periph_clk_en_o[1])
        else $error("sleep-enabled peripheral lost its clock");

    a_gating_disabled: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE7]
        (!gating_en_i && !sw_rst_r) |=> (periph_clk_en_o == $past(run_en_r)))
        else $error("gating off yet clock enables differ from run enables");

    a_cause_sw_set: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE10]
        (sw_rst_r && !ev_ext_i) |=> cause_r[sgrc_pkg::CAUSE_SW_BIT]
        && ((($past(cause_r) & ~$past(cause_clear_i)) & ~cause_r) == 5'h00))
        else $error("software reset flag not recorded");

    a_cause_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE12]
        (!ev_ext_i && cause_r[sgrc_pkg::CAUSE_WDOG_BIT] && !cause_clear_i[sgrc_pkg::CAUSE_WDOG_BIT])
        |=> cause_r[sgrc_pkg::CAUSE_WDOG_BIT])
        else $error("cause flag dropped without clear");

    a_cause_clear_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE13]
        (!ev_ext_i && !ev_por_i && cause_clear_i[sgrc_pkg::CAUSE_POR_BIT]) |=> !cause_r[sgrc_pkg::CAUSE_POR_BIT])
        else $error("selected cause flag not cleared");

    a_enable_latency: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE16]
        ($rose(run_en_r[0]) && !sw_rst_r) |-> !periph_ready_o[0] [*5]
        ##1 (periph_ready_o[0] || !run_en_r[0] || sw_rst_r))
        else $error("peripheral ready at wrong cycle");

    a_prst_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE17]
        (periph_reset_req_i[0] && !sw_rst_r) |=> periph_rst_o[0] [*4])
        else $error("peripheral reset pulse too short");

    a_wake_sleep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE6]
        (pstate_r == sgrc_pkg::SGRC_SLEEP && !sw_rst_r && |wake_nxt) |=> pstate_r == sgrc_pkg::SGRC_RUN)
        else $error("wake request ignored");

endmodule : sgrc_top

// File: verilog/sgrc_pkg.sv
package sgrc_pkg;
    // Peripheral slots and optional pin count
    localparam int unsigned NUM_PERIPH         = 24;
    localparam int unsigned NUM_PINS           = 17;
    // Enable latency after the enabling write
    localparam int unsigned ENABLE_LAT_CYC     = 5;
    // Width of the per-peripheral reset pulse
    localparam int unsigned PRST_PULSE_CYC     = 4;
    localparam int unsigned CNT_W              = 3;
    // Cause register bit positions
    localparam int unsigned CAUSE_W            = 5;
    localparam int unsigned CAUSE_EXT_BIT      = 0;
    localparam int unsigned CAUSE_POR_BIT      = 1;
    localparam int unsigned CAUSE_BOR_BIT      = 2;
    localparam int unsigned CAUSE_WDOG_BIT     = 3;
    localparam int unsigned CAUSE_SW_BIT       = 4;
    localparam logic [4:0]  CAUSE_RESET_VAL    = 5'h00;
    // Power state of the processor
    typedef enum logic [1:0] {
        SGRC_RUN   = 2'b01,
        SGRC_SLEEP = 2'b10
    } sgrc_pstate_t;
endpackage : sgrc_pkg

// File: tb/sgrc_periph_model.sv
`timescale 1ns/1ps
module sgrc_periph_model #(
    parameter int unsigned NP = sgrc_pkg::NUM_PERIPH
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // Gated clock enables from the block
    input  wire logic [NP-1:0] clk_en_i,
    // Wake commands from the testbench
    input  wire logic [NP-1:0] wake_cmd_i,
    // Wake requests and activity of peripheral 0
    output logic      [NP-1:0] periph_wake_o,
    output logic      [7:0]    act0_o
);
    // Counts only on enabled clocks, so a frozen peripheral keeps its count
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act0_o <= 8'h00;
        end else if (clk_en_i[0]) begin
            act0_o <= act0_o + 8'h01;
        end
    end

    // A peripheral without a clock has no logic running to raise a wake
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            periph_wake_o <= '0;
        end else begin
            periph_wake_o <= wake_cmd_i & clk_en_i;
        end
    end
endmodule : sgrc_periph_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int unsigned NP = sgrc_pkg::NUM_PERIPH;
    localparam int unsigned NI = sgrc_pkg::NUM_PINS;
    logic          clk_i = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          ev_ext, ev_por, ev_bor, ev_wdog, sw_rst, gate, slp_req;
    logic [NP-1:0] run_set, run_clr, slp_set, slp_clr, prst_req, access, wcmd, wake;
    logic [NP-1:0] clk_en, ready, prst, slp_en, present;
    logic [NI-1:0] pins;
    logic          fault, sys_rst, sleeping, wake_o;
    logic [4:0]    cclr, cause;
    logic [7:0]    act0, a;
    int            num_errors = 0;
    int            checks = 0;
    int            cycles = 0;
    int            rst_cnt = 0;
    logic          wake_seen = 1'b0;
    logic          fault_seen = 1'b0;
    logic          sys_seen = 1'b0;

    sgrc_top #(.PERIPH_PRESENT(24'h7fffff), .PIN_PRESENT(17'h1fffe)) sgrc_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ev_ext_i(ev_ext), .ev_por_i(ev_por),
        .ev_bor_i(ev_bor), .ev_wdog_i(ev_wdog), .sw_reset_req_i(sw_rst), .gating_en_i(gate),
        .run_en_set_i(run_set), .run_en_clr_i(run_clr), .sleep_en_set_i(slp_set),
        .sleep_en_clr_i(slp_clr), .periph_reset_req_i(prst_req), .cause_clear_i(cclr),
        .sleep_req_i(slp_req), .periph_wake_i(wake), .periph_access_i(access),
        .periph_clk_en_o(clk_en), .periph_ready_o(ready), .periph_rst_o(prst),
        .bus_fault_o(fault), .sys_reset_o(sys_rst), .cpu_sleeping_o(sleeping),
        .wake_o(wake_o), .cause_o(cause), .sleep_en_o(slp_en),
        .periph_present_o(present), .pin_present_o(pins));

    sgrc_periph_model #(.NP(NP)) sgrc_periph_model_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .wake_cmd_i(wcmd),
        .periph_wake_o(wake), .act0_o(act0));

    always #50 clk_i = ~clk_i;

    // One-cycle pulses are caught here so checks need not hit the exact cycle
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (wake_o === 1'b1) wake_seen <= 1'b1;
        if (fault === 1'b1) fault_seen <= 1'b1;
        if (sys_rst === 1'b1) sys_seen <= 1'b1;
        if (prst[0] === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [4:0] cb(input int unsigned b);
        return 5'h01 << b;
    endfunction : cb

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic await_wake();
        for (int n = 0; n < 20 && sleeping !== 1'b0; n++) tick(1);
    endtask : await_wake

    initial begin
        {ev_ext, ev_por, ev_bor, ev_wdog, sw_rst, gate, slp_req} = '0;
        {run_set, run_clr, slp_set, slp_clr, prst_req, access, wcmd} = '0;
        cclr = 5'h00;
        tick(16);
        rst_b_i = 1'b1;
        tick(1);
        check(cause, 5'h00, "cause after reset");
        check(ready, '0, "ready after reset");
        check(present, 24'h7fffff, "peripheral presence");
        check(pins, 17'h1fffe, "pin presence");
        $display("test reset finished");

        // Enable latency, early access and an absent peripheral
        run_set = 24'h800004;
        tick(1);
        run_set = '0;
        access[2] = 1'b1;
        tick(1);
        access = '0;
        tick(2);
        check(ready[2], 1'b0, "ready too early");
        check(fault_seen, 1'b1, "early access fault");
        tick(3);
        check(ready[2], 1'b1, "ready after latency");
        check(ready[23], 1'b0, "absent peripheral enabled");
        fault_seen = 1'b0;
        access[2] = 1'b1;
        tick(1);
        access = '0;
        tick(3);
        check(fault_seen, 1'b0, "fault on ready peripheral");
        $display("test enable finished");

        // Sleep with gating off, then on
        run_set = 24'h000003;
        slp_set = 24'h000002;
        tick(1);
        {run_set, slp_set} = '0;
        tick(8);
        check(slp_en, 24'h000002, "sleep enable stored");
        slp_req = 1'b1;
        tick(1);
        slp_req = 1'b0;
        tick(4);
        check(sleeping, 1'b1, "sleep entered");
        check(clk_en[1:0], 2'b11, "clocks with gating off");
        check(ready, 24'h000007, "run setting in sleep");
        wcmd = 24'h000002;
        await_wake();
        wcmd = '0;
        check(wake_seen, 1'b1, "wake pulse");
        gate = 1'b1;
        tick(2);
        slp_req = 1'b1;
        tick(1);
        slp_req = 1'b0;
        tick(4);
        a = act0;
        check(clk_en[1:0], 2'b10, "clocks with gating on");
        wcmd = 24'h000001;
        tick(5);
        wcmd = '0;
        check(sleeping, 1'b1, "wake from gated peripheral");
        check(act0, a, "frozen peripheral state");
        wake_seen = 1'b0;
        wcmd = 24'h000002;
        await_wake();
        wcmd = '0;
        tick(3);
        check(wake_seen, 1'b1, "wake pulse gated");
        check(clk_en[0], 1'b1, "clock after wake");
        check(act0 > a, 1'b1, "peripheral resumes");
        $display("test sleep finished");

        // Cause flags and software reset
        ev_wdog = 1'b1;
        tick(1);
        ev_wdog = 1'b0;
        ev_bor = 1'b1;
        tick(1);
        ev_bor = 1'b0;
        tick(2);
        check(cause, cb(sgrc_pkg::CAUSE_WDOG_BIT) | cb(sgrc_pkg::CAUSE_BOR_BIT), "accumulated causes");
        sw_rst = 1'b1;
        tick(1);
        sw_rst = 1'b0;
        tick(4);
        check(sys_seen, 1'b1, "system reset pulse");
        check(cause, cb(3) | cb(2) | cb(sgrc_pkg::CAUSE_SW_BIT), "cause after software reset");
        check(ready, '0, "enables after software reset");
        check(slp_en, '0, "sleep enables after software reset");
        cclr = cb(sgrc_pkg::CAUSE_WDOG_BIT);
        tick(1);
        cclr = 5'h00;
        ev_por = 1'b1;
        tick(1);
        ev_por = 1'b0;
        tick(2);
        check(cause, cb(2) | cb(4) | cb(sgrc_pkg::CAUSE_POR_BIT), "partial clear");
        ev_ext = 1'b1;
        tick(1);
        ev_ext = 1'b0;
        tick(2);
        check(cause, cb(sgrc_pkg::CAUSE_EXT_BIT), "external reset wipes");
        cclr = 5'h1f;
        tick(1);
        cclr = 5'h00;
        tick(2);
        check(cause, 5'h00, "clear all");
        $display("test cause finished");

        // Per-peripheral reset leaves the peripheral enabled
        run_set = 24'h000001;
        tick(1);
        run_set = '0;
        tick(8);
        rst_cnt = 0;
        prst_req = 24'h000001;
        tick(1);
        prst_req = '0;
        tick(8);
        check(rst_cnt, sgrc_pkg::PRST_PULSE_CYC, "peripheral reset width");
        check(ready[0], 1'b1, "enabled after peripheral reset");
        $display("test peripheral reset finished");
        close_out();
    end
endmodule : testbench
